// ### rtl/pmic_event_pkg.sv
// pmic_event_pkg: constants, types and register map of the event logic
// assumes byte addressed classic wishbone, one 8-bit register per word
package pmic_event_pkg;

  // ****************************************************************
  // widths
  // ****************************************************************
  localparam int NUM_BANKS = 5;
  localparam int DATA_W = 32;
  localparam int ADR_W = 8;
  localparam int REG_W = 8;
  localparam int IDX_W = 6;
  localparam int IRQ_W = 3;

  // ****************************************************************
  // register indices, byte address is four times the index
  // ****************************************************************
  localparam logic [NUM_BANKS-1:0][IDX_W-1:0] IDX_STATUS =
    {6'h33, 6'h0B, 6'h0A, 6'h09, 6'h08};
  localparam logic [IDX_W-1:0] IDX_CLEAR_BASE = 6'h10;
  localparam logic [IDX_W-1:0] IDX_MASK_BASE = 6'h15;
  localparam logic [IDX_W-1:0] IDX_CFG = 6'h1B;
  localparam logic [IDX_W-1:0] IDX_MODE = 6'h2F;
  localparam logic [IDX_W-1:0] IDX_IRQ_STAT = 6'h3C;
  localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 6'h3D;

  // ****************************************************************
  // bit classes per bank, bank 0 is status 0x08 ... bank 4 is 0x33
  // ****************************************************************
  localparam logic [NUM_BANKS-1:0][REG_W-1:0] IMPL_BITS =
    {8'h04, 8'hBB, 8'hBC, 8'hAB, 8'h6D};
  localparam logic [NUM_BANKS-1:0][REG_W-1:0] NOCLR_BITS =
    {8'h00, 8'h00, 8'h00, 8'h00, 8'h40};
  localparam logic [NUM_BANKS-1:0][REG_W-1:0] OFF_BITS =
    {8'h00, 8'h0B, 8'hB0, 8'h00, 8'h41};
  localparam logic [NUM_BANKS-1:0][REG_W-1:0] PGOOD_BITS =
    {8'h04, 8'h00, 8'h00, 8'h20, 8'h2C};
  localparam int CRIT_BIT = 6;
  localparam int CFG_IRQ_EN_BIT = 3;

  // ****************************************************************
  // reset values and interrupt bits
  // ****************************************************************
  localparam logic [REG_W-1:0] CFG_RESET = 8'h00;
  localparam logic [REG_W-1:0] MASK_RESET = 8'h00;
  localparam int IRQ_NEW_EVENT = 0;
  localparam int IRQ_OFF = 1;
  localparam int IRQ_PG_LOST = 2;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [1:0] {
    PG_MODE_HOLD = 2'h0,
    PG_MODE_REL_A = 2'h1,
    PG_MODE_REL_B = 2'h2,
    PG_MODE_SPARE = 2'h3
  } pg_mode_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_ACK = 2'b10
  } wb_state_t;

  typedef struct packed {
    logic [REG_W-1:0] st33;
    logic [REG_W-1:0] st0b;
    logic [REG_W-1:0] st0a;
    logic [REG_W-1:0] st09;
    logic [REG_W-1:0] st08;
  } event_vec_t;

endpackage

// ### rtl/event_bank.sv
// event_bank: one 8-bit sticky status register with clear on write one
// assumes event levels and clear pulses synchronous to clk_i
`timescale 1ns/100ps
module event_bank
  import pmic_event_pkg::*;
#(
  parameter logic [REG_W-1:0] IMPL = 8'hFF,
  parameter logic [REG_W-1:0] NOCLR = 8'h00
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [REG_W-1:0] event_i,
  input wire logic [REG_W-1:0] clear_i,
  output logic [REG_W-1:0] status_o
);

  logic [REG_W-1:0] drop;

  // clear only where the event is gone; a live event always wins
  assign drop = clear_i & ~event_i & ~NOCLR;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_o <= '0;
    end else begin
      status_o <= ((status_o & ~drop) | event_i) & IMPL;
    end
  end

endmodule // event_bank

// ### rtl/irq_sticky.sv
// irq_sticky: sticky interrupt status, mask and level interrupt output
// assumes event pulses and write strobes synchronous to clk_i
`timescale 1ns/100ps
module irq_sticky
  import pmic_event_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [IRQ_W-1:0] event_i,
  input wire logic [IRQ_W-1:0] w1c_i,
  input wire logic mask_wr_i,
  input wire logic [IRQ_W-1:0] mask_d_i,
  output logic [IRQ_W-1:0] status_o,
  output logic [IRQ_W-1:0] mask_o,
  output logic irq_o
);

  logic [IRQ_W-1:0] next_status;

  // set wins over a same-cycle clear
  assign next_status = (status_o & ~w1c_i) | event_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_o <= '0;
      irq_o <= 1'b0;
    end else begin
      status_o <= next_status;
      irq_o <= |(next_status & mask_o);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_o <= '0;
    end else if (mask_wr_i) begin
      mask_o <= mask_d_i;
    end
  end

endmodule // irq_sticky

// ### rtl/pmic_event_irq.sv
// pmic_event_irq: event latch, clear, mask, interrupt and power-ok logic
// assumes a classic wishbone master and event levels on clk_i
//
// The Wishbone interface to the registers and the register addresses were decided locally.
`timescale 1ns/100ps
module pmic_event_irq
  import pmic_event_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [DATA_W-1:0] wb_dat_i,
  output logic wb_ack_o,
  output logic [DATA_W-1:0] wb_dat_o,
  input wire event_vec_t events_i,
  output logic general_status_irq_n_o,
  output logic general_status_irq_n_oe_o,
  output logic power_ok_out_o,
  output logic regulator_off_request_o,
  output logic irq_o
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  wb_state_t state;
  logic [NUM_BANKS-1:0][REG_W-1:0] ev;
  logic [NUM_BANKS-1:0][REG_W-1:0] status;
  logic [NUM_BANKS-1:0][REG_W-1:0] mask;
  logic [NUM_BANKS-1:0][REG_W-1:0] clr_pulse;
  logic [NUM_BANKS-1:0][REG_W-1:0] clr_gone;
  logic [NUM_BANKS-1:0][REG_W-1:0] clr_held;
  logic [REG_W-1:0] cfg;
  pg_mode_t mode;
  logic [IDX_W-1:0] idx;
  logic [REG_W-1:0] wbyte;
  logic [REG_W-1:0] rd_byte;
  logic wr_fire;
  logic gsi_req;
  logic pg_unm;
  logic pg_masked;
  logic crit_hold;
  logic mode_release;
  logic pg_req;
  logic next_off;
  logic [IRQ_W-1:0] irq_ev;
  logic [IRQ_W-1:0] irq_w1c;
  logic [IRQ_W-1:0] irq_stat;
  logic [IRQ_W-1:0] irq_mask;
  logic irq_mask_wr;

  // ****************************************************************
  // decode helpers
  // ****************************************************************
  function automatic logic idx_hit(input logic [IDX_W-1:0] i,
                                   input logic [IDX_W-1:0] base,
                                   input int b);
    return i == (base + IDX_W'(b));
  endfunction

  assign idx = wb_adr_i[ADR_W-1:2];
  assign wbyte = wb_dat_i[REG_W-1:0];
  assign ev = events_i & IMPL_BITS;
  // a write takes effect at the edge where the master samples ack
  assign wr_fire = (state == ST_ACK) && wb_cyc_i && wb_stb_i && wb_we_i &&
                   wb_sel_i[0];

  // ****************************************************************
  // wishbone slave
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (wb_cyc_i && wb_stb_i) begin
            state <= ST_ACK;
            wb_ack_o <= 1'b1;
            wb_dat_o <= {{(DATA_W-REG_W){1'b0}}, rd_byte};
          end
        end
        ST_ACK: begin
          state <= ST_IDLE;
          wb_ack_o <= 1'b0;
        end
        default: begin
          state <= ST_IDLE;
          wb_ack_o <= 1'b0;
        end
      endcase
    end
  end

  // read mux; clear registers and unmapped words read zero
  always_comb begin
    rd_byte = '0;
    for (int b = 0; b < NUM_BANKS; b++) begin
      if (idx == IDX_STATUS[b]) begin
        rd_byte = status[b];
      end
      if (idx_hit(idx, IDX_MASK_BASE, b)) begin
        rd_byte = mask[b];
      end
    end
    if (idx == IDX_CFG) begin
      rd_byte = cfg;
    end
    if (idx == IDX_MODE) begin
      rd_byte = {{(REG_W-2){1'b0}}, mode};
    end
    if (idx == IDX_IRQ_STAT) begin
      rd_byte = {{(REG_W-IRQ_W){1'b0}}, irq_stat};
    end
    if (idx == IDX_IRQ_MASK) begin
      rd_byte = {{(REG_W-IRQ_W){1'b0}}, irq_mask};
    end
  end

  // ****************************************************************
  // clear strobes and status banks
  // ****************************************************************
  always_comb begin
    for (int b = 0; b < NUM_BANKS; b++) begin
      clr_pulse[b] = '0;
      if (wr_fire && idx_hit(idx, IDX_CLEAR_BASE, b)) begin
        clr_pulse[b] = wbyte;
      end
    end
  end

  assign clr_gone = clr_pulse & ~ev & ~NOCLR_BITS;
  assign clr_held = clr_pulse & ev;

  for (genvar g = 0; g < NUM_BANKS; g++) begin : g_bank
    event_bank #(
      .IMPL(IMPL_BITS[g]),
      .NOCLR(NOCLR_BITS[g])
    ) u_bank (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .event_i(ev[g]),
      .clear_i(clr_pulse[g]),
      .status_o(status[g])
    );
  end

  // ****************************************************************
  // configuration registers
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int b = 0; b < NUM_BANKS; b++) begin
        mask[b] <= MASK_RESET;
      end
    end else begin
      for (int b = 0; b < NUM_BANKS; b++) begin
        if (wr_fire && idx_hit(idx, IDX_MASK_BASE, b)) begin
          // critical temperature has no mask bit
          mask[b] <= wbyte & IMPL_BITS[b] & ~NOCLR_BITS[b];
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg <= CFG_RESET;
    end else if (wr_fire && idx == IDX_CFG) begin
      cfg <= wbyte;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode <= PG_MODE_HOLD;
    end else if (wr_fire && idx == IDX_MODE) begin
      mode <= pg_mode_t'(wbyte[1:0]);
    end
  end

  // ****************************************************************
  // output requests
  // ****************************************************************
  // masks gate outputs only; status and off request ignore them
  assign gsi_req = |(status & ~mask);
  assign pg_unm = |(status & PGOOD_BITS & ~mask);
  assign pg_masked = |(status & PGOOD_BITS & mask);
  assign crit_hold = |(status & NOCLR_BITS);
  assign mode_release = (mode == PG_MODE_REL_A) || (mode == PG_MODE_REL_B);
  // only off-class events raise the off request
  assign next_off = regulator_off_request_o | (|(ev & OFF_BITS));
  assign pg_req = regulator_off_request_o | pg_unm | crit_hold |
                  (pg_masked && !mode_release);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      regulator_off_request_o <= 1'b0;
    end else begin
      // held until power cycle; never cleared by software
      regulator_off_request_o <= next_off;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      general_status_irq_n_oe_o <= 1'b0;
      power_ok_out_o <= 1'b0;
    end else begin
      general_status_irq_n_oe_o <= cfg[CFG_IRQ_EN_BIT] && gsi_req;
      power_ok_out_o <= !pg_req;
    end
  end

  // open drain: only ever pulls low
  assign general_status_irq_n_o = 1'b0;

  // ****************************************************************
  // interrupt to local processor
  // ****************************************************************
  assign irq_ev[IRQ_NEW_EVENT] = |(ev & ~status);
  assign irq_ev[IRQ_OFF] = next_off && !regulator_off_request_o;
  assign irq_ev[IRQ_PG_LOST] = power_ok_out_o && pg_req;
  assign irq_w1c = (wr_fire && idx == IDX_IRQ_STAT) ? wbyte[IRQ_W-1:0] : '0;
  assign irq_mask_wr = wr_fire && (idx == IDX_IRQ_MASK);

  irq_sticky u_irq (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .event_i(irq_ev),
    .w1c_i(irq_w1c),
    .mask_wr_i(irq_mask_wr),
    .mask_d_i(wbyte[IRQ_W-1:0]),
    .status_o(irq_stat),
    .mask_o(irq_mask),
    .irq_o(irq_o)
  );

  // ****************************************************************
  // assertions
  // ****************************************************************
  sequence s_event;
    |ev;
  endsequence

  sequence s_clear_gone;
    |clr_gone;
  endsequence

  sequence s_off_then_pg;
    regulator_off_request_o ##1 !power_ok_out_o;
  endsequence

  property p_latch;
    @(posedge clk_i) disable iff (rst_i)
      s_event |=> ((status & $past(ev)) == $past(ev));
  endproperty
  a_latch: assert property (p_latch)
    else $error("event not latched in status");

  property p_off_set;
    @(posedge clk_i) disable iff (rst_i)
      (|(ev & OFF_BITS)) |=> s_off_then_pg;
  endproperty
  a_off_set: assert property (p_off_set)
    else $error("off event did not raise request and drop power ok");

  property p_off_cause;
    @(posedge clk_i) disable iff (rst_i)
      $rose(regulator_off_request_o) |-> $past(|(ev & OFF_BITS));
  endproperty
  a_off_cause: assert property (p_off_cause)
    else $error("off request raised by non off event");

  property p_pg_drop;
    @(posedge clk_i) disable iff (rst_i)
      pg_unm |=> !power_ok_out_o;
  endproperty
  a_pg_drop: assert property (p_pg_drop)
    else $error("unmasked power good loss kept power ok high");

  property p_crit;
    @(posedge clk_i) disable iff (rst_i)
      (status[0][CRIT_BIT] && cfg[CFG_IRQ_EN_BIT]) |=>
        (general_status_irq_n_oe_o && !power_ok_out_o);
  endproperty
  a_crit: assert property (p_crit)
    else $error("critical temperature not holding outputs");

  property p_gsi_cause;
    @(posedge clk_i) disable iff (rst_i)
      general_status_irq_n_oe_o |-> $past(|(status & ~mask));
  endproperty
  a_gsi_cause: assert property (p_gsi_cause)
    else $error("interrupt pin driven without unmasked status");

  property p_clear_done;
    @(posedge clk_i) disable iff (rst_i)
      s_clear_gone |=> ((status & $past(clr_gone)) == '0);
  endproperty
  a_clear_done: assert property (p_clear_done)
    else $error("cleared status bit still set");

  property p_clear_held;
    @(posedge clk_i) disable iff (rst_i)
      (|clr_held) |=> ((status & $past(clr_held)) == $past(clr_held));
  endproperty
  a_clear_held: assert property (p_clear_held)
    else $error("status cleared while event present");

  property p_irq_off;
    @(posedge clk_i) disable iff (rst_i)
      !cfg[CFG_IRQ_EN_BIT] |=> !general_status_irq_n_oe_o;
  endproperty
  a_irq_off: assert property (p_irq_off)
    else $error("interrupt pin driven while disabled");

  property p_mode_release;
    @(posedge clk_i) disable iff (rst_i)
      (mode_release && !pg_unm && !crit_hold && !next_off &&
       !regulator_off_request_o) |=> power_ok_out_o;
  endproperty
  a_mode_release: assert property (p_mode_release)
    else $error("power ok low with masked events in release mode");

endmodule // pmic_event_irq

// ### sim/wb_host_model.sv
// wb_host_model: classic wishbone master standing in for the sideband host
// assumes a slave on clk_i that answers every request with an ack
`timescale 1ns/100ps
module wb_host_model
  import pmic_event_pkg::*;
(
  input wire logic clk_i,
  output logic wb_cyc_o,
  output logic wb_stb_o,
  output logic wb_we_o,
  output logic [ADR_W-1:0] wb_adr_o,
  output logic [3:0] wb_sel_o,
  output logic [DATA_W-1:0] wb_dat_o,
  input wire logic wb_ack_i,
  input wire logic [DATA_W-1:0] wb_dat_i
);
  // ********
  // idle bus
  // ********
  initial begin
    wb_cyc_o = 1'b0;
    wb_stb_o = 1'b0;
    wb_we_o = 1'b0;
    wb_adr_o = '0;
    wb_sel_o = 4'h0;
    wb_dat_o = '0;
  end

  // ********
  // one access, held until ack is sampled or 64 cycles pass, then released
  // ********
  task automatic access(input logic we, input logic [ADR_W-1:0] adr,
      input logic [DATA_W-1:0] wdat, output logic [DATA_W-1:0] rdat,
      output logic ok);
    int n;
    n = 0;
    ok = 1'b0;
    rdat = '0;
    @(posedge clk_i);
    wb_cyc_o <= 1'b1;
    wb_stb_o <= 1'b1;
    wb_we_o <= we;
    wb_adr_o <= adr;
    wb_sel_o <= 4'h1;
    wb_dat_o <= wdat;
    while (!ok && n < 64) begin
      @(posedge clk_i);
      n++;
      if (wb_ack_i === 1'b1) begin
        ok = 1'b1;
        rdat = wb_dat_i;
      end
    end
    wb_cyc_o <= 1'b0;
    wb_stb_o <= 1'b0;
    wb_we_o <= 1'b0;
    wb_adr_o <= ~adr;
    wb_sel_o <= 4'h0;
    wb_dat_o <= ~wdat;
  endtask
endmodule // wb_host_model

// ### sim/tb.sv
// tb: self-checking bench of event latch, clear, mask and power-ok logic
// assumes the host model drives the bus; events are driven here
`timescale 1ns/100ps
module tb;
  import pmic_event_pkg::*;
  localparam logic [7:0] CFG_ADR = 8'h6C;
  localparam logic [7:0] MODE_ADR = 8'hBC;
  localparam logic [7:0] IRQS_ADR = 8'hF0;
  localparam logic [7:0] IRQM_ADR = 8'hF4;
  localparam logic [7:0] STAT_ADR [0:4] = '{8'h20, 8'h24, 8'h28, 8'h2C, 8'hCC};
  localparam logic [7:0] IMPL_EV [0:4] = '{8'h6D, 8'hAB, 8'hBC, 8'hBB, 8'h04};
  localparam logic [7:0] OFF_EV [0:4] = '{8'h41, 8'h00, 8'hB0, 8'h0B, 8'h00};
  localparam logic [7:0] PG_EV [0:4] = '{8'h2C, 8'h20, 8'h00, 8'h00, 8'h04};
  logic clk_i, rst_i, cyc, stb, we, ack, oe, pok_o, off_o, irq;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] dat_w, dat_r, r;
  event_vec_t events;
  int miscompares, checks_done;
  logic [7:0] bit_one;
  logic is_off, en, msk, pok;
  logic [1:0] mode;
  logic [2:0] im;

  pmic_event_irq pmic_event_irq_i (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_ack_o(ack), .wb_dat_o(dat_r),
    .events_i(events), .general_status_irq_n_o(),
    .general_status_irq_n_oe_o(oe), .power_ok_out_o(pok_o),
    .regulator_off_request_o(off_o), .irq_o(irq));
  wb_host_model wb_host_model_i (.clk_i(clk_i), .wb_cyc_o(cyc),
    .wb_stb_o(stb), .wb_we_o(we), .wb_adr_o(adr), .wb_sel_o(sel),
    .wb_dat_o(dat_w), .wb_ack_i(ack), .wb_dat_i(dat_r));

  // ********
  // helpers
  // ********
  task automatic wrap_up();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
      output logic [31:0] q);
    logic ok;
    wb_host_model_i.access(w, a, {24'h0, d}, q, ok);
    if (ok !== 1'b1) begin
      miscompares++;
      $display("[FAIL] bus ack expected 1 seen 0");
      wrap_up();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd_chk(input string what, input logic [7:0] a,
      input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, q);
    chk(what, q, exp);
  endtask
  task automatic outs(input logic e_oe, e_pok, e_off, e_irq);
    @(negedge clk_i);
    chk("irq pin enable", 32'(oe), 32'(e_oe));
    chk("power ok", 32'(pok_o), 32'(e_pok));
    chk("off request", 32'(off_o), 32'(e_off));
    chk("irq level", 32'(irq), 32'(e_irq));
  endtask
  task automatic do_reset();
    @(posedge clk_i);
    rst_i <= 1'b1;
    events <= '0;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
  endtask

  // ********
  // clock and watchdog
  // ********
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  initial begin
    repeat (100000) @(posedge clk_i);
    miscompares++;
    $display("[FAIL] run end expected done seen hang");
    wrap_up();
  end

  // ********
  // main sequence
  // ********
  initial begin
    rst_i = 1'b1;
    events = '0;
    miscompares = 0;
    checks_done = 0;
    void'($urandom(57));
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    outs(1'b0, 1'b1, 1'b0, 1'b0);
    rd_chk("cfg reset", CFG_ADR, 32'h0);
    rd_chk("mask reset", 8'h54, 32'h0);
    wr(STAT_ADR[0], 8'hFF);
    rd_chk("status read only", STAT_ADR[0], 32'h0);
    rd_chk("clear reads zero", 8'h40, 32'h0);
    rd_chk("unmapped", 8'hFC, 32'h0);
    $display("test registers done");
    for (int b = 0; b < 5; b++) begin
      for (int i = 0; i < 8; i++) begin
        if (IMPL_EV[b][i] && !(b == 0 && i == 6)) begin
          bit_one = 8'h01 << i;
          is_off = OFF_EV[b][i];
          en = ($urandom % 4) != 0;
          msk = 1'($urandom % 2);
          mode = 2'($urandom % 3);
          im = 3'($urandom % 8);
          pok = !is_off && !(PG_EV[b][i] && (!msk || mode == 2'h0));
          do_reset();
          wr(CFG_ADR, {4'h0, en, 3'h0});
          wr(MODE_ADR, {6'h0, mode});
          wr(IRQM_ADR, {5'h0, im});
          if (msk) wr(8'h54 + 8'(4 * b), bit_one);
          @(posedge clk_i);
          events <= event_vec_t'(40'h1 << (8 * b + i));
          wr(8'h40 + 8'(4 * b), bit_one);
          rd_chk("status held", STAT_ADR[b], {24'h0, bit_one});
          @(posedge clk_i);
          events <= '0;
          rd_chk("status", STAT_ADR[b], {24'h0, bit_one});
          bus(1'b0, IRQS_ADR, 8'h00, r);
          chk("irq status", 32'(r[2:0]), {29'h0, !pok, is_off, 1'b1});
          outs(en && !msk, pok, is_off, |({!pok, is_off, 1'b1} & im));
          wr(8'h40 + 8'(4 * b), bit_one);
          rd_chk("status cleared", STAT_ADR[b], 32'h0);
          wr(IRQS_ADR, 8'h07);
          outs(1'b0, !is_off, is_off, 1'b0);
        end
      end
    end
    $display("test event classes done");
    do_reset();
    wr(CFG_ADR, 8'h08);
    wr(8'h54, 8'hFF);
    wr(IRQM_ADR, 8'h07);
    @(posedge clk_i);
    events <= event_vec_t'(40'h40);
    @(posedge clk_i);
    events <= '0;
    wr(8'h40, 8'h40);
    rd_chk("crit status", STAT_ADR[0], 32'h40);
    bus(1'b0, 8'h54, 8'h00, r);
    chk("crit mask bit", 32'(r[6]), 32'h0);
    outs(1'b1, 1'b0, 1'b1, 1'b1);
    $display("test critical temperature done");
    wrap_up();
  end
endmodule // tb
